// [design/ucc_regs.vh]
// register map and timing of the serial block
`ifndef UCC_REGS_VH
`define UCC_REGS_VH

// register indices; the byte address is four times the index
`define UCC_IDX_LINE      6'h13
`define UCC_IDX_TXRX      6'h14
`define UCC_IDX_NINTH     6'h15
`define UCC_IDX_STAT      6'h16
`define UCC_IDX_DATA      6'h18
`define UCC_ADDR_LINE     {`UCC_IDX_LINE, 2'b00}
`define UCC_ADDR_TXRX     {`UCC_IDX_TXRX, 2'b00}
`define UCC_ADDR_NINTH    {`UCC_IDX_NINTH, 2'b00}
`define UCC_ADDR_STAT     {`UCC_IDX_STAT, 2'b00}
`define UCC_ADDR_DATA     {`UCC_IDX_DATA, 2'b00}

// line_format_control fields
`define UCC_LOOP_BIT      7
`define UCC_MODEN_BIT     6
`define UCC_INV_BIT       5
`define UCC_NINE_BIT      4
`define UCC_WAKE_BIT      3
`define UCC_IDLE_COUNT_AFTER_STOP_BIT      2
`define UCC_PAR_BIT       1
`define UCC_ODD_BIT       0

// tx_rx_control fields
`define UCC_TEIE_BIT      7
`define UCC_TX_DONE_IRQ_EN_BIT      6
`define UCC_RFIE_BIT      5
`define UCC_IDLE_IRQ_EN_BIT      4
`define UCC_TE_BIT        3
`define UCC_RE_BIT        2
`define UCC_RWU_BIT       1
`define UCC_BRK_BIT       0

// ninth_bit_error_irq_control fields
`define UCC_R8_BIT        7
`define UCC_T8_BIT        6
`define UCC_OVERRUN_IRQ_EN_BIT      3
`define UCC_FEIE_BIT      1
`define UCC_PEIE_BIT      0

// status fields
`define UCC_ST_TBE        7
`define UCC_ST_TC         6
`define UCC_ST_RF         5
`define UCC_ST_IDLE       4
`define UCC_ST_OR         3
`define UCC_ST_FE         1
`define UCC_ST_PE         0

// reset values
`define UCC_LINE_RST      8'h00
`define UCC_TXRX_RST      8'h00

// timing
`define UCC_CLK_NS        8'd10
`define UCC_BIT_NS        8'd160
`define UCC_BIT_CYCLES    (`UCC_BIT_NS / `UCC_CLK_NS)
`define UCC_LEN8          4'd10
`define UCC_LEN9          4'd11

`endif

// [design/ucc_tx.v]
// transmitter: preamble, break, idle and data shifter
`timescale 1ns/1ps
`default_nettype none
`include "ucc_regs.vh"
module ucc_tx (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // control
    input  wire       enable,
    input  wire       tx_enable,
    input  wire       break_send,
    input  wire       char_9bit,
    input  wire       parity_on,
    input  wire       odd_parity_sel,
    // data buffer
    input  wire       load_valid,
    input  wire [8:0] load_data,
    output wire       load_take,
    // line
    output wire       active,
    output reg        line
);
    localparam [7:0] BIT_LAST = `UCC_BIT_CYCLES - 8'd1;

    reg  [10:0] sh;
    reg  [3:0]  left;
    reg  [7:0]  div;
    reg         te_d;
    reg         preamble_pend;
    reg         idle_pend;
    reg         guard_pend;

    wire [3:0]  len  = char_9bit ? `UCC_LEN9 : `UCC_LEN8;
    wire        free = (left == 4'd0) && enable && tx_enable;
    wire [8:0]  pay;
    assign pay[6:0] = load_data[6:0];
    assign pay[7]   = (parity_on && !char_9bit) ? (^load_data[6:0]) ^ odd_parity_sel : load_data[7]; // RQ5 RQ6
    assign pay[8]   = (parity_on && char_9bit) ? (^load_data[7:0]) ^ odd_parity_sel : load_data[8];  // RQ5 RQ6
    wire [10:0] frame = char_9bit ? {1'b1, pay, 1'b0} : {2'b11, pay[7:0], 1'b0}; // RQ4

    // break ranks first, so a break toggled before the preamble replaces it
    wire start_brk   = free && break_send;                                   // RQ17 RQ18
    wire start_guard = free && !break_send && guard_pend;
    wire start_pre   = free && !break_send && !guard_pend && preamble_pend;
    wire start_idle  = free && !break_send && !guard_pend && !preamble_pend && idle_pend;
    assign load_take = free && !break_send && !guard_pend && !preamble_pend && !idle_pend && load_valid;
    assign active    = (left != 4'd0) | preamble_pend | idle_pend | guard_pend | (break_send & tx_enable); // RQ24

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh            <= 11'h7FF;
            left          <= 4'd0;
            div           <= 8'h00;
            te_d          <= 1'b0;
            preamble_pend <= 1'b0;
            idle_pend     <= 1'b0;
            guard_pend    <= 1'b0;
            line          <= 1'b1;
        end else if (!enable) begin
            left          <= 4'd0;
            div           <= 8'h00;
            te_d          <= 1'b0;
            preamble_pend <= 1'b0;
            idle_pend     <= 1'b0;
            guard_pend    <= 1'b0;
            line          <= 1'b1;
        end else begin
            te_d <= tx_enable;
            if (tx_enable && !te_d) begin
                if (left != 4'd0)
                    idle_pend <= 1'b1;     // RQ13
                else
                    preamble_pend <= 1'b1; // RQ11
            end
            if (left != 4'd0) begin
                // a started character completes unless the module is disabled
                if (div == BIT_LAST) begin // RQ12
                    div  <= 8'h00;
                    sh   <= {1'b1, sh[10:1]};
                    left <= left - 4'd1;
                    line <= (left == 4'd1) ? 1'b1 : sh[1];
                end else begin
                    div <= div + 8'd1;
                end
            end else begin
                div <= 8'h00;
                if (start_brk) begin
                    sh            <= 11'h000;
                    left          <= len;
                    line          <= 1'b0;
                    guard_pend    <= 1'b1; // RQ17
                    preamble_pend <= 1'b0;
                end else if (start_guard) begin
                    sh         <= 11'h7FF;
                    left       <= 4'd1;
                    line       <= 1'b1;
                    guard_pend <= 1'b0;
                end else if (start_pre || start_idle) begin
                    sh            <= 11'h7FF;
                    left          <= len;  // RQ11
                    line          <= 1'b1;
                    preamble_pend <= 1'b0;
                    if (!start_pre)
                        idle_pend <= 1'b0;
                end else if (load_take) begin
                    sh   <= frame;         // RQ20
                    left <= len;
                    line <= frame[0];
                end else begin
                    line <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [design/ucc_top.v]
// serial control block: apb registers, receiver, flags
// Contract
// [RQ1] loopback feeds transmitter output to receiver
// [RQ2] module disable sets tx flags, masks tx irq
// [RQ3] inversion flips every transmitted level
// [RQ4] one start, one stop, 10/11-bit characters
// [RQ5] parity sits in the character msb
// [RQ6] parity type one odd, zero even
// [RQ7] wake bit selects address mark or idle
// [RQ8] idle count starts after stop or start
// [RQ9] tx irq from empty or done flags
// [RQ10] rx irq from full or idle flags
// [RQ11] enabling transmitter sends one all-ones preamble
// [RQ12] disabling transmitter finishes current character
// [RQ13] enable toggle mid-character queues idle character
// [RQ14] software leaves enables alone while disabled
// [RQ15] receiver disable keeps receiver flags
// [RQ16] standby mutes rx irq, cleared on wakeup
// [RQ17] break bit sends breaks then single one
// [RQ18] software avoids break toggle before preamble
// [RQ19] received ninth bit captured, reset-free, mirrored
// [RQ20] tx ninth bit loaded with buffer data
// [RQ21] error irq from overrun and its enable
// [RQ22] reset clears all control bits
// [RQ23] buffer transfer sets empty flag, reset sets
// [RQ24] done flag when idle, cleared when queued
// [RQ25] irq outputs are or of enabled flags
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ucc_regs.vh"
module ucc_top (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // serial pins
    input  wire        rxd,
    output reg         txd,
    output wire        txd_oe,
    // interrupt requests
    output wire        irq_tx,
    output wire        irq_rx,
    output wire        irq_err
);
    localparam [7:0] BIT_LAST = `UCC_BIT_CYCLES - 8'd1;
    localparam [7:0] BIT_HALF = `UCC_BIT_CYCLES >> 1;

    // control registers
    reg  [7:0] line_format_control;
    reg  [7:0] tx_rx_control;
    reg        tx_ninth_bit;
    reg        overrun_irq_en;
    reg        frame_err_irq_en;
    reg        parity_err_irq_en;
    reg        rx_ninth_bit;
    reg  [7:0] rx_data_buf;
    reg  [7:0] tx_data_buf;

    // status flags
    reg        tx_buffer_empty_flag;
    reg        tx_done_flag;
    reg        rx_full_flag;
    reg        idle_flag;
    reg        overrun_flag;
    reg        frame_err_flag;
    reg        parity_err_flag;
    reg  [7:0] seen;
    reg        idle_armed;

    // receiver state
    reg        rx_sync1;
    reg        rx_sync2;
    reg        rx_busy;
    reg  [7:0] rx_div;
    reg  [3:0] rx_cnt;
    reg  [3:0] ones;
    reg  [9:0] rx_sh;

    wire       internal_loopback     = line_format_control[`UCC_LOOP_BIT];
    wire       module_enable         = line_format_control[`UCC_MODEN_BIT];
    wire       tx_polarity_invert    = line_format_control[`UCC_INV_BIT];
    wire       char_9bit             = line_format_control[`UCC_NINE_BIT];
    wire       addr_mark_wake        = line_format_control[`UCC_WAKE_BIT];
    wire       idle_count_after_stop = line_format_control[`UCC_IDLE_COUNT_AFTER_STOP_BIT];
    wire       parity_on             = line_format_control[`UCC_PAR_BIT];
    wire       odd_parity_sel        = line_format_control[`UCC_ODD_BIT];
    wire       tx_empty_irq_en       = tx_rx_control[`UCC_TEIE_BIT];
    wire       tx_done_irq_en        = tx_rx_control[`UCC_TX_DONE_IRQ_EN_BIT];
    wire       rx_full_irq_en        = tx_rx_control[`UCC_RFIE_BIT];
    wire       idle_irq_en           = tx_rx_control[`UCC_IDLE_IRQ_EN_BIT];
    wire       tx_enable             = tx_rx_control[`UCC_TE_BIT];
    wire       rx_enable             = tx_rx_control[`UCC_RE_BIT];
    wire       rx_standby            = tx_rx_control[`UCC_RWU_BIT];
    wire       break_send            = tx_rx_control[`UCC_BRK_BIT];

    // apb decode, no wait states
    wire       acc      = psel && penable;
    wire       mapped   = (paddr == `UCC_ADDR_LINE) || (paddr == `UCC_ADDR_TXRX) ||
                          (paddr == `UCC_ADDR_NINTH) || (paddr == `UCC_ADDR_STAT) ||
                          (paddr == `UCC_ADDR_DATA);
    wire       wr       = acc && pwrite && mapped;
    wire       stat_rd  = acc && !pwrite && (paddr == `UCC_ADDR_STAT);
    wire       data_rd  = acc && !pwrite && (paddr == `UCC_ADDR_DATA);
    wire       data_wr  = wr && (paddr == `UCC_ADDR_DATA);
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    wire [7:0] status = {tx_buffer_empty_flag, tx_done_flag, rx_full_flag, idle_flag,
                         overrun_flag, 1'b0, frame_err_flag, parity_err_flag};

    // transmitter
    wire       tx_take;
    wire       tx_active;
    wire       tx_line;

    ucc_tx u_tx (
        .pclk           (pclk),
        .presetn        (presetn),
        .enable         (module_enable),
        .tx_enable      (tx_enable),
        .break_send     (break_send),
        .char_9bit      (char_9bit),
        .parity_on      (parity_on),
        .odd_parity_sel (odd_parity_sel),
        .load_valid     (!tx_buffer_empty_flag),
        .load_data      ({tx_ninth_bit, tx_data_buf}),
        .load_take      (tx_take),
        .active         (tx_active),
        .line           (tx_line)
    );

    // receiver datapath
    wire       rx_in    = internal_loopback ? tx_line : rx_sync2; // RQ1
    wire       rx_run   = module_enable && rx_enable;             // RQ15
    wire       rx_tick  = (rx_div == BIT_LAST);
    wire [3:0] len      = char_9bit ? `UCC_LEN9 : `UCC_LEN8;      // RQ4
    wire [9:0] nsh      = {rx_in, rx_sh[9:1]};
    wire       last     = rx_run && rx_busy && rx_tick && (rx_cnt == len - 4'd1);
    wire [8:0] word     = char_9bit ? nsh[8:0] : {1'b0, nsh[8:1]};
    wire       msb      = char_9bit ? word[8] : word[7];
    wire       perr     = (char_9bit ? (^word[8:0]) : (^word[7:0])) ^ odd_parity_sel; // RQ5 RQ6
    wire       accept   = last && (!rx_standby || (addr_mark_wake && msb));           // RQ7 RQ16
    wire       rx_load  = accept && !rx_full_flag;
    wire       rx_over  = accept && rx_full_flag;
    wire       idle_evt = rx_run && !rx_busy && rx_in && rx_tick && (ones == len - 4'd1); // RQ8
    wire       wake_clr = (last && rx_standby && addr_mark_wake && msb) ||
                          (idle_evt && rx_standby && !addr_mark_wake);                // RQ7 RQ16

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sync1 <= 1'b1;
            rx_sync2 <= 1'b1;
        end else begin
            rx_sync1 <= rxd;
            rx_sync2 <= rx_sync1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_busy <= 1'b0;
            rx_div  <= 8'h00;
            rx_cnt  <= 4'd0;
            ones    <= 4'd0;
            rx_sh   <= 10'h000;
        end else if (!rx_run) begin
            rx_busy <= 1'b0;
            rx_div  <= 8'h00;
            rx_cnt  <= 4'd0;
            ones    <= 4'd0;
        end else begin
            rx_div <= rx_tick ? 8'h00 : rx_div + 8'd1;
            if (!rx_busy) begin
                if (!rx_in) begin
                    // mid-bit sampling
                    rx_busy <= 1'b1;
                    rx_div  <= BIT_HALF;
                    rx_cnt  <= 4'd0;
                    ones    <= 4'd0;
                end else if (rx_tick && ones != len) begin
                    ones <= ones + 4'd1;
                end
            end else if (rx_tick) begin
                rx_cnt <= rx_cnt + 4'd1;
                if (rx_cnt == 4'd0) begin
                    if (rx_in)
                        rx_busy <= 1'b0;
                end else begin
                    rx_sh <= nsh;
                    ones  <= (!idle_count_after_stop && rx_in) ? ones + 4'd1 : 4'd0; // RQ8
                    if (last)
                        rx_busy <= 1'b0;
                end
            end
        end
    end

    // rx data and ninth bit are not reset
    always @(posedge pclk) begin
        if (rx_load) begin
            rx_data_buf  <= word[7:0];
            rx_ninth_bit <= msb; // RQ19
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_format_control <= `UCC_LINE_RST; // RQ22
            tx_rx_control       <= `UCC_TXRX_RST; // RQ22
            tx_ninth_bit        <= 1'b0;
            overrun_irq_en      <= 1'b0;
            frame_err_irq_en    <= 1'b0;
            parity_err_irq_en   <= 1'b0;
            tx_data_buf         <= 8'h00;
        end else begin
            if (wr && paddr == `UCC_ADDR_LINE)
                line_format_control <= pwdata[7:0];
            if (wr && paddr == `UCC_ADDR_TXRX)
                tx_rx_control <= pwdata[7:0];
            if (wake_clr)
                tx_rx_control[`UCC_RWU_BIT] <= 1'b0; // RQ16
            if (wr && paddr == `UCC_ADDR_NINTH) begin
                tx_ninth_bit      <= pwdata[`UCC_T8_BIT];
                overrun_irq_en    <= pwdata[`UCC_OVERRUN_IRQ_EN_BIT];
                frame_err_irq_en  <= pwdata[`UCC_FEIE_BIT];
                parity_err_irq_en <= pwdata[`UCC_PEIE_BIT];
            end
            if (data_wr)
                tx_data_buf <= pwdata[7:0];
        end
    end

    // flags: set beats clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buffer_empty_flag <= 1'b1; // RQ23
            tx_done_flag         <= 1'b1;
            rx_full_flag         <= 1'b0;
            idle_flag            <= 1'b0;
            overrun_flag         <= 1'b0;
            frame_err_flag       <= 1'b0;
            parity_err_flag      <= 1'b0;
            seen                 <= 8'h00;
            idle_armed           <= 1'b0;
        end else begin
            if (!module_enable || tx_take)
                tx_buffer_empty_flag <= 1'b1; // RQ2 RQ23
            else if (data_wr && seen[`UCC_ST_TBE])
                tx_buffer_empty_flag <= 1'b0;
            tx_done_flag <= !module_enable || (tx_buffer_empty_flag && !tx_active && !tx_take); // RQ2 RQ24
            if (rx_load)
                rx_full_flag <= 1'b1;
            else if (data_rd && seen[`UCC_ST_RF])
                rx_full_flag <= 1'b0;
            if (idle_evt && idle_armed && !rx_standby)
                idle_flag <= 1'b1;
            else if (data_rd && seen[`UCC_ST_IDLE])
                idle_flag <= 1'b0;
            if (rx_over)
                overrun_flag <= 1'b1;
            else if (data_rd && seen[`UCC_ST_OR])
                overrun_flag <= 1'b0;
            if (rx_load && !nsh[9])
                frame_err_flag <= 1'b1;
            else if (data_rd && seen[`UCC_ST_FE])
                frame_err_flag <= 1'b0;
            if (rx_load && parity_on && perr)
                parity_err_flag <= 1'b1; // RQ5
            else if (data_rd && seen[`UCC_ST_PE])
                parity_err_flag <= 1'b0;
            // idle needs a new character first
            if (rx_load)
                idle_armed <= 1'b1;
            else if (idle_evt && idle_armed && !rx_standby)
                idle_armed <= 1'b0;
            if (stat_rd)
                seen <= prdata[7:0];
            else if (data_rd || data_wr)
                seen <= 8'h00;
        end
    end

    // read data captured in setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `UCC_ADDR_LINE:  prdata <= {24'h000000, line_format_control};
                `UCC_ADDR_TXRX:  prdata <= {24'h000000, tx_rx_control};
                `UCC_ADDR_NINTH: prdata <= {24'h000000, rx_ninth_bit, tx_ninth_bit, 2'b00,
                                            overrun_irq_en, 1'b0, frame_err_irq_en, parity_err_irq_en};
                `UCC_ADDR_STAT:  prdata <= {24'h000000, status};
                `UCC_ADDR_DATA:  prdata <= {24'h000000, rx_data_buf};
                default:         prdata <= 32'h00000000;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            txd <= 1'b1;
        else
            txd <= tx_line ^ tx_polarity_invert; // RQ3
    end
    assign txd_oe = module_enable;

    assign irq_tx  = module_enable && ((tx_buffer_empty_flag && tx_empty_irq_en) ||
                                       (tx_done_flag && tx_done_irq_en));          // RQ2 RQ9 RQ25
    assign irq_rx  = !rx_standby && ((rx_full_flag && rx_full_irq_en) ||
                                     (idle_flag && idle_irq_en));                  // RQ10 RQ16 RQ25
    assign irq_err = (overrun_flag && overrun_irq_en) || (frame_err_flag && frame_err_irq_en) ||
                     (parity_err_flag && parity_err_irq_en);                       // RQ21 RQ25
endmodule
`default_nettype wire

// [tb/ucc_sva.sv]
// port assertions of the serial block
`timescale 1ns/1ps
`default_nettype none
`include "ucc_regs.vh"
module ucc_sva (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // line and requests
    input wire logic        txd,
    input wire logic        txd_oe,
    input wire logic        irq_tx,
    input wire logic        irq_rx,
    input wire logic        irq_err
);
    logic [7:0] line_sh;
    logic [7:0] txrx_sh;
    logic [7:0] ninth_sh;
    wire        acc = psel && penable;
    wire        rdx = acc && !pwrite;
    wire        mapped = paddr == `UCC_ADDR_LINE || paddr == `UCC_ADDR_TXRX || paddr == `UCC_ADDR_NINTH
                         || paddr == `UCC_ADDR_STAT || paddr == `UCC_ADDR_DATA;
    // software-written shadows
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_sh  <= `UCC_LINE_RST;
            txrx_sh  <= `UCC_TXRX_RST;
            ninth_sh <= 8'h00;
        end else if (acc && pwrite) begin
            if (paddr == `UCC_ADDR_LINE) line_sh <= pwdata[7:0];
            if (paddr == `UCC_ADDR_TXRX) txrx_sh <= pwdata[7:0];
            if (paddr == `UCC_ADDR_NINTH) ninth_sh <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // module off, polarity steady 3 cycles
    sequence quiet_s;
        (!line_sh[`UCC_MODEN_BIT] && $stable(line_sh[`UCC_INV_BIT])) [*3];
    endsequence
    a_pready_high: assert property (pready) else $error("pready low");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped not refused");
    a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("mapped refused");
    a_line_readback: assert property (rdx && paddr == `UCC_ADDR_LINE |-> prdata == {24'h0, line_sh})
        else $error("line readback");
    a_txrx_readback: assert property (rdx && paddr == `UCC_ADDR_TXRX |-> (prdata[7:0] & 8'hFD) == (txrx_sh & 8'hFD))
        else $error("txrx readback");
    a_ninth_readback: assert property (rdx && paddr == `UCC_ADDR_NINTH |-> (prdata[7:0] & 8'h4B) == (ninth_sh & 8'h4B))
        else $error("ninth readback");
    a_oe_enable: assert property (txd_oe == line_sh[`UCC_MODEN_BIT]) else $error("pin enable wrong");
    a_txirq_src: assert property (irq_tx |-> txd_oe && (txrx_sh[7] || txrx_sh[6]))
        else $error("tx irq unenabled");
    a_rxirq_src: assert property (irq_rx |-> txrx_sh[5] || txrx_sh[4]) else $error("rx irq unenabled");
    a_errirq_src: assert property (irq_err |-> (ninth_sh & 8'h0B) != 8'h00)
        else $error("err irq unenabled");
    a_idle_level: assert property (quiet_s |-> txd == !line_sh[`UCC_INV_BIT]) else $error("idle level wrong");
endmodule
`default_nettype wire

// [tb/ucc_node.sv]
// remote node driving rxd
`timescale 1ns/1ps
`default_nettype none
`include "ucc_regs.vh"
module ucc_node (
    // clock
    input  wire logic pclk,
    // line
    output var  logic rxd
);
    initial rxd = 1'b1;
    // lsb first, 11 bit times
    task automatic send(input logic [10:0] f);
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (`UCC_BIT_CYCLES) @(posedge pclk);
        end
        rxd <= 1'b1;
    endtask
endmodule
`default_nettype wire

// [tb/uart_control_config_tb.sv]
// serial block bench
`timescale 1ns/1ps
`default_nettype none
`include "ucc_regs.vh"
module uart_control_config_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, rxd, txd, txd_oe, irq_tx, irq_rx, irq_err, err_seen;
    logic [10:0] f;
    logic [7:0]  modes [7] = '{8'h63, 8'h42, 8'h43, 8'h50, 8'h52, 8'h53, 8'h40};
    int          errors = 0, n_tests = 0, m, cyc;
    always #5 pclk = ~pclk;
    ucc_top u_ucc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                       .pslverr, .rxd, .txd, .txd_oe, .irq_tx, .irq_rx, .irq_err);
    ucc_node u_ucc_node (.pclk, .rxd);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd       = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // expected line bits in send order; m is {nine, parity, odd}
    function automatic logic [10:0] frame(input logic [7:0] d, input logic t8, input logic [2:0] m);
        logic p;
        p = (m[2] ? ^d : ^d[6:0]) ^ m[0];
        if (!m[2]) return {2'b11, m[1] ? p : d[7], d[6:0], 1'b0};
        return {1'b1, m[1] ? p : t8, d, 1'b0};
    endfunction
    task automatic grab(input logic inv, output logic [10:0] g, output int c);
        c = 0;
        while (txd !== inv && c < 2000) begin
            @(posedge pclk);
            c++;
        end
        repeat (8) @(posedge pclk);
        for (int i = 0; i < 11; i++) begin
            g[i] = txd ^ inv;
            repeat (`UCC_BIT_CYCLES) @(posedge pclk);
        end
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h5730));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `UCC_ADDR_LINE, 0);
        chk(rd, 0);
        apb(0, `UCC_ADDR_TXRX, 0);
        chk(rd, 0);
        apb(0, `UCC_ADDR_NINTH, 0);
        chk(rd & 32'h4B, 0);
        apb(0, `UCC_ADDR_STAT, 0);
        chk(rd, 32'hC0);
        apb(0, 8'h5C, 0);
        chk({err_seen, rd}, {1'b1, 32'h0});
        for (int i = 0; i < 8; i++) begin
            m = $urandom;
            apb(1, `UCC_ADDR_LINE, 8'h40 | (m[7:0] & 8'h1F));
            apb(1, `UCC_ADDR_TXRX, m[15:8] & 8'hF0);
            apb(1, `UCC_ADDR_NINTH, m[23:16]);
            apb(0, `UCC_ADDR_NINTH, 0);
            chk(rd & 32'h4B, m[23:16] & 8'h4B);
            chk({irq_tx, irq_rx, irq_err}, {m[15] | m[14], 2'b00});
        end
        apb(1, `UCC_ADDR_TXRX, 8'h80);
        apb(1, `UCC_ADDR_LINE, 8'h00);
        @(posedge pclk);
        chk({irq_tx, txd_oe}, 0);
        // every format, first behind preamble
        for (int i = 0; i < 7; i++) begin
            m = $urandom;
            apb(1, `UCC_ADDR_LINE, modes[i]);
            if (i == 0) apb(1, `UCC_ADDR_TXRX, 8'h08);
            apb(1, `UCC_ADDR_NINTH, {1'b0, m[8], 6'h0});
            apb(0, `UCC_ADDR_STAT, 0);
            apb(1, `UCC_ADDR_DATA, m[7:0]);
            chk(txd, !modes[i][5]);
            grab(modes[i][5], f, cyc);
            chk(f, frame(m[7:0], m[8], {modes[i][4], modes[i][1:0]}));
            if (i == 0) chk(32'(cyc > 140), 1);
        end
        apb(0, `UCC_ADDR_STAT, 0);
        apb(1, `UCC_ADDR_DATA, 8'h96);
        apb(1, `UCC_ADDR_TXRX, 8'h00);
        grab(1'b0, f, cyc);
        chk({txd, f}, {1'b1, frame(8'h96, 1'b0, 3'b000)});
        // rx: 8-bit mirror, then ninth bit
        m = $urandom;
        apb(1, `UCC_ADDR_TXRX, 8'h24);
        u_ucc_node.send(frame(m[7:0], 1'b0, 3'b000));
        chk(irq_rx, 1);
        apb(0, `UCC_ADDR_NINTH, 0);
        chk(rd[7], m[7]);
        apb(0, `UCC_ADDR_STAT, 0);
        apb(0, `UCC_ADDR_DATA, 0);
        chk(rd[7:0], m[7:0]);
        apb(1, `UCC_ADDR_LINE, 8'h50);
        u_ucc_node.send(frame(m[15:8], 1'b1, 3'b100));
        apb(0, `UCC_ADDR_NINTH, 0);
        chk(rd[7], 1);
        apb(0, `UCC_ADDR_STAT, 0);
        apb(0, `UCC_ADDR_DATA, 0);
        // address-mark wake, overrun kept with rx off
        apb(1, `UCC_ADDR_LINE, 8'h48);
        apb(1, `UCC_ADDR_TXRX, 8'h26);
        apb(1, `UCC_ADDR_NINTH, 8'h08);
        u_ucc_node.send(frame(8'h81, 1'b0, 3'b000));
        apb(0, `UCC_ADDR_TXRX, 0);
        chk(rd[1], 0);
        u_ucc_node.send(frame(8'h3C, 1'b0, 3'b000));
        chk(irq_err, 1);
        apb(1, `UCC_ADDR_TXRX, 8'h20);
        apb(0, `UCC_ADDR_STAT, 0);
        chk(rd & 32'h28, 32'h28);
        end_sim();
    end
endmodule
bind ucc_top ucc_sva u_ucc_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                                .pslverr, .txd, .txd_oe, .irq_tx, .irq_rx, .irq_err);
`default_nettype wire
